// file: mcp_cfg.svh
// Register offsets, field positions, reset values and timing counts of the provisioning bank
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH

`define MCP_ADDR_PROV 8'h14
`define MCP_ADDR_RSTCTL 8'h15

`define MCP_PROV_UNEQ_ALL 4
`define MCP_PROV_AIS_SRC 3
`define MCP_PROV_RDI_CNT 2
`define MCP_PROV_AIS_LOP 1
`define MCP_PROV_HW_IRQ 0
`define MCP_PROV_MASK 8'h1f
`define MCP_PROV_RESET 8'h00

`define MCP_RC_SOFT_RST 7
`define MCP_RC_CLR_A 6
`define MCP_RC_CLR_B 5
`define MCP_RC_PROC_RST 4
`define MCP_RC_RAM_INIT 0

`define MCP_RDI_RUN_LONG 4'ha
`define MCP_RDI_RUN_SHORT 4'h5

`define MCP_SOFT_RST_CYCLES 8
`define MCP_ALARM_CLR_CYCLES 4
`define MCP_PROC_RST_CYCLES 8

`endif

// file: mcp_pkg.sv
// Types shared by the provisioning bank
`default_nettype none
package mcp_pkg;
  typedef enum logic [1:0] {
    MCP_INIT_IDLE = 2'h0,
    MCP_INIT_WAIT = 2'h1,
    MCP_INIT_SWEEP = 2'h3
  } mcp_init_state_type;
endpackage
`default_nettype wire

// file: mcp_ram.sv
// Processor data RAM with registered read data
`default_nettype none
module mcp_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic core_clk_i,
  // Access port
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// file: mcp_regs.sv
// Common provisioning and reset control registers with the logic they steer
`include "mcp_cfg.svh"
`default_nettype none
module mcp_regs #(
  parameter int RAM_AW = 8,
  parameter int RAM_DW = 8,
  parameter int SOFT_RST_CYCLES = `MCP_SOFT_RST_CYCLES,
  parameter int ALARM_CLR_CYCLES = `MCP_ALARM_CLR_CYCLES,
  parameter int PROC_RST_CYCLES = `MCP_PROC_RST_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Microprocessor register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Unequipped channel routing
  input wire logic mux_mode_i,
  input wire logic drop_on_b_i,
  input wire logic active_bus_b_i,
  input wire logic unequip_req_i,
  output logic unequip_send_a_o,
  output logic unequip_send_b_o,
  // AIS detection
  input wire logic stm1_format_i,
  input wire logic [2:0] ais_ptr_i,
  input wire logic [2:0] ais_e1_i,
  output logic [2:0] ais_detect_o,
  // V5 RDI
  input wire logic rdi_valid_i,
  input wire logic rdi_bit_i,
  output logic rdi_alarm_o,
  // Pointer tracking
  input wire logic ptr_ais_to_lop_i,
  output logic ptr_ais_to_lop_o,
  // Interrupt lead
  input wire logic irq_event_i,
  output logic irq_lead_o,
  // Control pulses to the datapath
  output logic soft_reset_o,
  output logic bus_highz_set_o,
  output logic clear_a_side_alarms_o,
  output logic clear_b_side_alarms_o,
  output logic proc_core_reset_o,
  // Processor data RAM port
  input wire logic proc_ram_we_i,
  input wire logic [RAM_AW-1:0] proc_ram_addr_i,
  input wire logic [RAM_DW-1:0] proc_ram_wdata_i,
  output logic [RAM_DW-1:0] proc_ram_rdata_o,
  output logic proc_ram_ready_o
);
  import mcp_pkg::*;

  function automatic logic cnt_last(input logic [7:0] cnt, input int limit);
    cnt_last = (cnt == 8'(limit - 1));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  logic [7:0] prov_r;
  logic wr_prov, wr_rst;
  logic soft_busy_r, clr_a_busy_r, clr_b_busy_r, proc_busy_r;
  logic [7:0] soft_cnt_r, clr_a_cnt_r, clr_b_cnt_r, proc_cnt_r;
  mcp_init_state_type init_state_r;
  logic [RAM_AW-1:0] init_addr_r;

  assign wr_prov = reg_wr_i && (reg_addr_i == `MCP_ADDR_PROV);
  assign wr_rst = reg_wr_i && (reg_addr_i == `MCP_ADDR_RSTCTL);

  // Unused bits are dropped whatever software writes
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prov_r <= `MCP_PROV_RESET;
    end else if (soft_busy_r) begin
      prov_r <= `MCP_PROV_RESET;
    end else if (wr_prov) begin
      prov_r <= reg_wdata_i & `MCP_PROV_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-clearing actions

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_busy_r <= 1'b0;
      soft_cnt_r <= 8'h00;
    end else if (!soft_busy_r) begin
      soft_cnt_r <= 8'h00;
      if (wr_rst && reg_wdata_i[`MCP_RC_SOFT_RST]) begin
        soft_busy_r <= 1'b1;
      end
    end else if (cnt_last(soft_cnt_r, SOFT_RST_CYCLES)) begin
      soft_busy_r <= 1'b0;
    end else begin
      soft_cnt_r <= soft_cnt_r + 8'h01;
    end
  end

  // Both clears may start from the same write
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_a_busy_r <= 1'b0;
      clr_a_cnt_r <= 8'h00;
    end else if (!clr_a_busy_r) begin
      clr_a_cnt_r <= 8'h00;
      if (wr_rst && reg_wdata_i[`MCP_RC_CLR_A]) begin
        clr_a_busy_r <= 1'b1;
      end
    end else if (cnt_last(clr_a_cnt_r, ALARM_CLR_CYCLES)) begin
      clr_a_busy_r <= 1'b0;
    end else begin
      clr_a_cnt_r <= clr_a_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_b_busy_r <= 1'b0;
      clr_b_cnt_r <= 8'h00;
    end else if (!clr_b_busy_r) begin
      clr_b_cnt_r <= 8'h00;
      if (wr_rst && reg_wdata_i[`MCP_RC_CLR_B]) begin
        clr_b_busy_r <= 1'b1;
      end
    end else if (cnt_last(clr_b_cnt_r, ALARM_CLR_CYCLES)) begin
      clr_b_busy_r <= 1'b0;
    end else begin
      clr_b_cnt_r <= clr_b_cnt_r + 8'h01;
    end
  end

  // Processor reset leaves the data RAM alone
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      proc_busy_r <= 1'b0;
      proc_cnt_r <= 8'h00;
    end else if (!proc_busy_r) begin
      proc_cnt_r <= 8'h00;
      if (wr_rst && reg_wdata_i[`MCP_RC_PROC_RST]) begin
        proc_busy_r <= 1'b1;
      end
    end else if (cnt_last(proc_cnt_r, PROC_RST_CYCLES)) begin
      proc_busy_r <= 1'b0;
    end else begin
      proc_cnt_r <= proc_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data RAM initialisation

  // Waits for a running soft reset, then writes zero to every word
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_state_r <= MCP_INIT_IDLE;
      init_addr_r <= '0;
    end else begin
      unique case (init_state_r)
        MCP_INIT_IDLE: begin
          init_addr_r <= '0;
          if (wr_rst && reg_wdata_i[`MCP_RC_RAM_INIT]) begin
            init_state_r <= MCP_INIT_WAIT;
          end
        end
        MCP_INIT_WAIT: begin
          if (!soft_busy_r) begin
            init_state_r <= MCP_INIT_SWEEP;
          end
        end
        MCP_INIT_SWEEP: begin
          init_addr_r <= init_addr_r + 1'b1;
          if (&init_addr_r) begin
            init_state_r <= MCP_INIT_IDLE;
          end
        end
        default: begin
          init_state_r <= MCP_INIT_IDLE;
        end
      endcase
    end
  end

  logic init_busy;
  logic init_sweep;
  assign init_busy = (init_state_r != MCP_INIT_IDLE);
  assign init_sweep = (init_state_r == MCP_INIT_SWEEP);

  mcp_ram #(
    .AW(RAM_AW),
    .DW(RAM_DW)
  ) u_ram (
    .core_clk_i(core_clk_i),
    .we_i(init_sweep ? 1'b1 : proc_ram_we_i),
    .addr_i(init_sweep ? init_addr_r : proc_ram_addr_i),
    .wdata_i(init_sweep ? '0 : proc_ram_wdata_i),
    .rdata_o(proc_ram_rdata_o)
  );

  assign proc_ram_ready_o = !init_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `MCP_ADDR_PROV) begin
        reg_rdata_o <= prov_r;
      end else if (reg_addr_i == `MCP_ADDR_RSTCTL) begin
        reg_rdata_o <= {soft_busy_r, clr_a_busy_r, clr_b_busy_r, proc_busy_r,
                        3'h0, init_busy};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steered behaviour

  logic uneq_all;
  assign uneq_all = prov_r[`MCP_PROV_UNEQ_ALL];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unequip_send_a_o <= 1'b0;
      unequip_send_b_o <= 1'b0;
    end else if (uneq_all) begin
      unequip_send_a_o <= unequip_req_i && !active_bus_b_i;
      unequip_send_b_o <= unequip_req_i && active_bus_b_i;
    end else begin
      unequip_send_a_o <= unequip_req_i && mux_mode_i && !drop_on_b_i;
      unequip_send_b_o <= unequip_req_i && mux_mode_i && drop_on_b_i;
    end
  end

  logic [2:0] ais_inst_en;
  assign ais_inst_en = stm1_format_i ? 3'h1 : 3'h7;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ais_detect_o <= 3'h0;
    end else if (prov_r[`MCP_PROV_AIS_SRC]) begin
      ais_detect_o <= ais_e1_i & ais_inst_en;
    end else begin
      ais_detect_o <= ais_ptr_i & ais_inst_en;
    end
  end

  // Alarm changes state after a run of samples that disagree with it
  logic [3:0] rdi_run_r;
  logic [3:0] rdi_need;
  assign rdi_need = prov_r[`MCP_PROV_RDI_CNT] ? `MCP_RDI_RUN_LONG : `MCP_RDI_RUN_SHORT;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdi_run_r <= 4'h0;
      rdi_alarm_o <= 1'b0;
    end else if (soft_busy_r) begin
      rdi_run_r <= 4'h0;
      rdi_alarm_o <= 1'b0;
    end else if (rdi_valid_i) begin
      if (rdi_bit_i == rdi_alarm_o) begin
        rdi_run_r <= 4'h0;
      end else if (rdi_run_r + 4'h1 >= rdi_need) begin
        rdi_run_r <= 4'h0;
        rdi_alarm_o <= rdi_bit_i;
      end else begin
        rdi_run_r <= rdi_run_r + 4'h1;
      end
    end
  end

  assign ptr_ais_to_lop_o = ptr_ais_to_lop_i && prov_r[`MCP_PROV_AIS_LOP];
  assign irq_lead_o = irq_event_i && prov_r[`MCP_PROV_HW_IRQ];

  assign soft_reset_o = soft_busy_r;
  assign bus_highz_set_o = soft_busy_r;
  assign clear_a_side_alarms_o = clr_a_busy_r;
  assign clear_b_side_alarms_o = clr_b_busy_r;
  assign proc_core_reset_o = proc_busy_r || init_sweep;
endmodule
`default_nettype wire

// file: mcp_regs_sva.sv
// Port assertions of the provisioning bank
`default_nettype none
module mcp_regs_sva #(
  parameter int SOFT_RST_CYCLES = 8,
  parameter int ALARM_CLR_CYCLES = 4
) (
  // Clock, reset and register port
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Watched controls
  input wire logic ptr_ais_to_lop_i,
  input wire logic ptr_ais_to_lop_o,
  input wire logic irq_event_i,
  input wire logic irq_lead_o,
  input wire logic soft_reset_o,
  input wire logic bus_highz_set_o,
  input wire logic clear_a_side_alarms_o,
  input wire logic clear_b_side_alarms_o,
  input wire logic proc_ram_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic wr_ctl;
  assign wr_ctl = reg_wr_i && reg_addr_i == 8'h15;
  // Shadow of the provisioning controls, built from the register port
  logic [4:0] prov_shadow_r;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prov_shadow_r <= 5'h00;
    end else if (soft_reset_o) begin
      prov_shadow_r <= 5'h00;
    end else if (reg_wr_i && reg_addr_i == 8'h14) begin
      prov_shadow_r <= reg_wdata_i[4:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  a_lop_gate: assert property (ptr_ais_to_lop_o ==
    (ptr_ais_to_lop_i && prov_shadow_r[1])) else $error("lop transition gate wrong");
  a_irq_gate: assert property (irq_lead_o ==
    (irq_event_i && prov_shadow_r[0])) else $error("irq lead gate wrong");
  a_clear_cause: assert property ($rose(clear_a_side_alarms_o) |->
    $past(wr_ctl && reg_wdata_i[6])) else $error("a clear without write");
  a_clear_both: assert property (wr_ctl && reg_wdata_i[6:5] == 2'h3 |=>
    clear_a_side_alarms_o && clear_b_side_alarms_o) else $error("joint clear lost");
  a_clear_len: assert property ($fell(clear_a_side_alarms_o) |->
    $past(clear_a_side_alarms_o, ALARM_CLR_CYCLES)
    && !$past(clear_a_side_alarms_o, ALARM_CLR_CYCLES + 1)) else $error("clear length");
  a_soft_len: assert property ($fell(soft_reset_o) |->
    $past(soft_reset_o, SOFT_RST_CYCLES)
    && !$past(soft_reset_o, SOFT_RST_CYCLES + 1)) else $error("soft reset length");
  a_highz_soft: assert property (wr_ctl && reg_wdata_i[7] && !soft_reset_o |=>
    soft_reset_o && bus_highz_set_o) else $error("high-z not set");
  a_init_busy: assert property (wr_ctl && reg_wdata_i[0] |=> !proc_ram_ready_o)
    else $error("ram ready during init");
  a_unused_zero: assert property (reg_rd_i && reg_addr_i == 8'h14 |=>
    reg_rdata_o[7:5] == 3'h0) else $error("unused bits read back");
  c_both: cover property (clear_a_side_alarms_o && clear_b_side_alarms_o);
  c_soft: cover property ($fell(soft_reset_o));
  c_init: cover property ($rose(proc_ram_ready_o));
endmodule
bind mcp_regs mcp_regs_sva #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES),
  .ALARM_CLR_CYCLES(ALARM_CLR_CYCLES)) u_sva (.core_clk_i, .rstn_i, .reg_addr_i,
  .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .ptr_ais_to_lop_i, .ptr_ais_to_lop_o,
  .irq_event_i, .irq_lead_o, .soft_reset_o, .bus_highz_set_o, .clear_a_side_alarms_o,
  .clear_b_side_alarms_o, .proc_ram_ready_o);
`default_nettype wire

// file: mcp_regs_test.sv
// Self-checking bench of the provisioning bank
`default_nettype none
module mcp_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, mux_mode_i = 0;
  logic drop_on_b_i = 0, active_bus_b_i = 0, unequip_req_i = 0, stm1_format_i = 0;
  logic rdi_valid_i = 0, rdi_bit_i = 0, ptr_ais_to_lop_i = 0, irq_event_i = 0;
  logic proc_ram_we_i = 0, unequip_send_a_o, unequip_send_b_o, rdi_alarm_o;
  logic ptr_ais_to_lop_o, irq_lead_o, soft_reset_o, bus_highz_set_o, proc_core_reset_o;
  logic clear_a_side_alarms_o, clear_b_side_alarms_o, proc_ram_ready_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, proc_ram_wdata_i = 0;
  logic [7:0] proc_ram_rdata_o;
  logic [3:0] proc_ram_addr_i = 0;
  logic [2:0] ais_ptr_i = 0, ais_e1_i = 0, ais_detect_o;
  int fails = 0, comparisons = 0, n;
  mcp_regs #(.RAM_AW(4)) dut (.core_clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .mux_mode_i, .drop_on_b_i, .active_bus_b_i,
    .unequip_req_i, .unequip_send_a_o, .unequip_send_b_o, .stm1_format_i, .ais_ptr_i,
    .ais_e1_i, .ais_detect_o, .rdi_valid_i, .rdi_bit_i, .rdi_alarm_o, .ptr_ais_to_lop_i,
    .ptr_ais_to_lop_o, .irq_event_i, .irq_lead_o, .soft_reset_o, .bus_highz_set_o,
    .clear_a_side_alarms_o, .clear_b_side_alarms_o, .proc_core_reset_o, .proc_ram_we_i,
    .proc_ram_addr_i, .proc_ram_wdata_i, .proc_ram_rdata_o, .proc_ram_ready_o);
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  task automatic wait_idle();
    n = 0;
    while ((soft_reset_o | clear_a_side_alarms_o | clear_b_side_alarms_o
        | proc_core_reset_o | !proc_ram_ready_o) !== 1'b0 && n < 100) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= 100) begin
      fails++;
      $display("MISMATCH %0t action never ended", $time);
      end_sim();
    end
  endtask
  task automatic uneq(input logic [7:0] p, input logic [2:0] mda, input logic [1:0] exp);
    wr(8'h14, p);
    @(posedge core_clk_i);
    {mux_mode_i, drop_on_b_i, active_bus_b_i} <= mda;
    unequip_req_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({unequip_send_a_o, unequip_send_b_o}, exp);
  endtask
  task automatic rdi(input int cnt, input logic v, input logic exp);
    @(posedge core_clk_i);
    rdi_valid_i <= 1'b1;
    rdi_bit_i <= v;
    repeat (cnt) @(posedge core_clk_i);
    rdi_valid_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk(rdi_alarm_o, exp);
  endtask
  task automatic ais(input logic [7:0] p, input logic fmt, input logic [2:0] exp);
    wr(8'h14, p);
    @(posedge core_clk_i);
    stm1_format_i <= fmt;
    ais_ptr_i <= 3'h5;
    ais_e1_i <= 3'h3;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(ais_detect_o, exp);
  endtask
  task automatic ram(input logic [7:0] exp);
    @(posedge core_clk_i);
    proc_ram_addr_i <= 4'h3;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(proc_ram_rdata_o, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h14, 8'h1f);
    rd(8'h14, 8'h1f);
    @(posedge core_clk_i);
    irq_event_i <= 1'b1;
    ptr_ais_to_lop_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({irq_lead_o, ptr_ais_to_lop_o}, 8'h3);
    wr(8'h14, 8'h1c);
    chk({irq_lead_o, ptr_ais_to_lop_o}, 8'h0);
    ais(8'h08, 1'b0, 3'h3);
    ais(8'h08, 1'b1, 3'h1);
    ais(8'h00, 1'b0, 3'h5);
    uneq(8'h00, 3'h4, 2'h2);
    uneq(8'h00, 3'h6, 2'h1);
    uneq(8'h00, 3'h0, 2'h0);
    uneq(8'h10, 3'h0, 2'h2);
    uneq(8'h10, 3'h3, 2'h1);
    rdi(4, 1'b1, 1'b0);
    rdi(1, 1'b1, 1'b1);
    wr(8'h14, 8'h04);
    rdi(9, 1'b0, 1'b1);
    rdi(1, 1'b1, 1'b1);
    rdi(9, 1'b0, 1'b1);
    rdi(1, 1'b0, 1'b0);
    wr(8'h15, 8'h60);
    chk({clear_a_side_alarms_o, clear_b_side_alarms_o}, 8'h3);
    wait_idle();
    chk(8'(n), 8'h04);
    rd(8'h15, 8'h00);
    wr(8'h14, 8'h1f);
    wr(8'h15, 8'h80);
    chk({soft_reset_o, bus_highz_set_o}, 8'h3);
    rd(8'h15, 8'h80);
    wait_idle();
    rd(8'h14, 8'h00);
    @(posedge core_clk_i);
    proc_ram_we_i <= 1'b1;
    proc_ram_addr_i <= 4'h3;
    proc_ram_wdata_i <= 8'ha5;
    @(posedge core_clk_i);
    proc_ram_we_i <= 1'b0;
    wr(8'h15, 8'h10);
    chk(proc_core_reset_o, 1'b1);
    wait_idle();
    ram(8'ha5);
    wr(8'h15, 8'h01);
    chk(proc_ram_ready_o, 1'b0);
    rd(8'h15, 8'h01);
    wait_idle();
    rd(8'h15, 8'h00);
    ram(8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
